/* File: hw/ifd_defines.vh */
// constants for the instruction format decoder
`ifndef IFD_DEFINES_VH
`define IFD_DEFINES_VH
`define IFD_WORD_W 14
`define IFD_OP_HI 13
`define IFD_OP_LO 8
`define IFD_DEST_BIT 7
`define IFD_FILE_HI 6
`define IFD_FILE_LO 0
`define IFD_BIT_HI 9
`define IFD_BIT_LO 7
`define IFD_LIT_HI 7
`define IFD_LIT_LO 0
`define IFD_JOP_HI 13
`define IFD_JOP_LO 11
`define IFD_JLIT_HI 10
`define IFD_JLIT_LO 0
`define IFD_CLS_HI 13
`define IFD_CLS_LO 12
`define IFD_SUB_HI 11
`define IFD_SUB_LO 8
`define IFD_BSUB_LO 10
`define IFD_CLS_BYTE 2'h0
`define IFD_CLS_BIT 2'h1
`define IFD_CLS_JUMP 2'h2
`define IFD_CLS_LIT 2'h3
`define IFD_DEST_W 1'h0
`define IFD_DEST_F 1'h1
`define IFD_PHASES 2'h3
`define IFD_BTFSC_SEL 2'h2
`define IFD_BTFSS_SEL 2'h3
`define IFD_DECSZ 4'hB
`define IFD_INCSZ 4'hF
`define IFD_RET 14'h0008
`define IFD_RETI 14'h0009
`define IFD_LIT_RET 2'h1
`define IFD_PCL_ADDR 7'h02
`endif

/* File: hw/ifd_phase_gen.v */
// four-phase instruction cycle divider
`timescale 1ns/1ns
`default_nettype none
`include "ifd_defines.vh"
module ifd_phase_gen (
    input wire ref_clk,
    input wire rst_b,
    output reg [1:0] phase,
    output reg cycle_end
);
    // divide by four: one instruction cycle is four clock periods
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= 2'h0;
            cycle_end <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            cycle_end <= (phase == (`IFD_PHASES - 2'h1));
        end
    end
endmodule // ifd_phase_gen
`default_nettype wire

/* File: hw/ifd_decoder.v */
// instruction format decoder with cycle timing
// Contract
// - sort each word into byte, bit, or literal and control class
// - file address is seven low bits, range 0x00 to 0x7F
// - byte ops: opcode 13:8, destination bit 7, file address 6:0
// - destination 0 writes accumulator, 1 writes file register
// - bit ops: 3-bit bit select plus 7-bit file address in low bits
// - literal ops: opcode 13:8, 8-bit immediate in 7:0
// - don't-care bits are ignored by the decoder
// - one instruction cycle unless skip taken or counter changed
// - taken skip or counter change costs two cycles, second a nop
// - one instruction cycle is four clock periods
// - literal is 8 bits general, 11 bits for call and jump
`timescale 1ns/1ns
`default_nettype none
`include "ifd_defines.vh"
module ifd_decoder (
    input wire ref_clk,
    input wire rst_b,
    input wire [13:0] instr_word,
    input wire skip_true,
    output reg [1:0] instr_class,
    output reg [5:0] opcode,
    output reg [2:0] jump_opcode,
    output reg dest_file,
    output reg dest_accum,
    output reg [6:0] file_addr,
    output reg [2:0] bit_sel,
    output reg [7:0] literal8,
    output reg [10:0] literal11,
    output reg write_enable,
    output reg is_nop_cycle,
    output reg counter_change,
    output reg [1:0] phase_out,
    output reg cycle_strobe
);
    wire [1:0] phase;
    wire cycle_end;
    reg flush;
    reg [1:0] next_class;
    reg next_change;
    reg next_cond;

    ifd_phase_gen u_phase (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .phase(phase),
        .cycle_end(cycle_end)
    );

    // class from the top two bits only; lower bits never alter class
    function [1:0] cls_of;
        input [13:0] w;
        begin
            cls_of = w[`IFD_CLS_HI:`IFD_CLS_LO];
        end
    endfunction

    // sub-opcode of the byte class, bits below the class pair
    function [3:0] byte_sub;
        input [13:0] w;
        begin
            byte_sub = w[`IFD_SUB_HI:`IFD_SUB_LO];
        end
    endfunction

    // two-bit sub-opcode shared by the bit and literal classes
    function [1:0] pair_sub;
        input [13:0] w;
        begin
            pair_sub = w[`IFD_SUB_HI:`IFD_BSUB_LO];
        end
    endfunction

    // decrement or increment with skip on zero
    function is_skip_byte;
        input [13:0] w;
        begin
            is_skip_byte = (byte_sub(w) == `IFD_DECSZ) ||
                (byte_sub(w) == `IFD_INCSZ);
        end
    endfunction

    // bit test with skip on clear or on set
    function is_skip_bit;
        input [13:0] w;
        begin
            is_skip_bit = (pair_sub(w) == `IFD_BTFSC_SEL) ||
                (pair_sub(w) == `IFD_BTFSS_SEL);
        end
    endfunction

    // subroutine and interrupt returns, matched on the whole word
    function is_return;
        input [13:0] w;
        begin
            is_return = (w == `IFD_RET) || (w == `IFD_RETI);
        end
    endfunction

    // any byte op writing back to the counter's low byte moves it,
    // clears and plain stores included, so the prefetch goes stale
    function is_pc_write;
        input [13:0] w;
        begin
            is_pc_write = (w[`IFD_DEST_BIT] == `IFD_DEST_F) &&
                (w[`IFD_FILE_HI:`IFD_FILE_LO] == `IFD_PCL_ADDR);
        end
    endfunction

    // byte class with the destination bit at the wanted value
    function dest_is;
        input [13:0] w;
        input d;
        begin
            dest_is = (cls_of(w) == `IFD_CLS_BYTE) &&
                (w[`IFD_DEST_BIT] == d);
        end
    endfunction

    always @* begin
        next_class = cls_of(instr_word);
        next_change = 1'b0;
        next_cond = 1'b0;
        case (next_class)
            `IFD_CLS_JUMP: begin
                next_change = 1'b1;
            end
            `IFD_CLS_LIT: begin
                // literal return: low sub-opcode bits are don't-care
                next_change = (pair_sub(instr_word) == `IFD_LIT_RET);
            end
            `IFD_CLS_BIT: begin
                next_cond = is_skip_bit(instr_word);
            end
            `IFD_CLS_BYTE: begin
                next_cond = is_skip_byte(instr_word);
                next_change = is_return(instr_word) ||
                    is_pc_write(instr_word);
            end
            default: begin
                next_change = 1'b0;
            end
        endcase
    end

    // phase view and cycle strobe follow the divider by one clock
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_out <= 2'h0;
            cycle_strobe <= 1'b0;
        end else begin
            phase_out <= phase;
            cycle_strobe <= cycle_end;
        end
    end

    // fields load on every boundary, nop cycles too, so the views
    // always match the word fetched last
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            instr_class <= `IFD_CLS_BYTE;
            opcode <= 6'h00;
            jump_opcode <= 3'h0;
            file_addr <= 7'h00;
            bit_sel <= 3'h0;
            literal8 <= 8'h00;
            literal11 <= 11'h000;
        end else if (cycle_end) begin
            instr_class <= next_class;
            opcode <= instr_word[`IFD_OP_HI:`IFD_OP_LO];
            jump_opcode <= instr_word[`IFD_JOP_HI:`IFD_JOP_LO];
            file_addr <= instr_word[`IFD_FILE_HI:`IFD_FILE_LO];
            bit_sel <= instr_word[`IFD_BIT_HI:`IFD_BIT_LO];
            literal8 <= instr_word[`IFD_LIT_HI:`IFD_LIT_LO];
            literal11 <= instr_word[`IFD_JLIT_HI:`IFD_JLIT_LO];
        end
    end

    // control: a pending flush turns the next word into a nop
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            write_enable <= 1'b0;
            dest_file <= 1'b0;
            dest_accum <= 1'b0;
            is_nop_cycle <= 1'b0;
            counter_change <= 1'b0;
            flush <= 1'b0;
        end else if (cycle_end) begin
            if (flush) begin
                // second cycle runs as a nop: prefetched word discarded
                write_enable <= 1'b0;
                dest_file <= 1'b0;
                dest_accum <= 1'b0;
                is_nop_cycle <= 1'b1;
                counter_change <= 1'b0;
                flush <= 1'b0;
            end else begin
                write_enable <= 1'b1;
                is_nop_cycle <= 1'b0;
                dest_file <= dest_is(instr_word, `IFD_DEST_F);
                dest_accum <= dest_is(instr_word, `IFD_DEST_W);
                counter_change <= next_change;
                // skip outcome only known to the datapath, taken here
                flush <= next_change || (next_cond && skip_true);
            end
        end
    end
endmodule // ifd_decoder
`default_nettype wire

/* File: testbench/ifd_props_properties.sv */
// port assertions for the instruction format decoder
`timescale 1ns/1ns
`default_nettype none
module ifd_props (
    input wire logic ref_clk, rst_b, cycle_strobe,
    input wire logic [13:0] instr_word,
    input wire logic [1:0] instr_class,
    input wire logic [1:0] phase_out,
    input wire logic [5:0] opcode,
    input wire logic [6:0] file_addr,
    input wire logic [2:0] bit_sel,
    input wire logic [10:0] literal11,
    input wire logic dest_file, dest_accum, write_enable, is_nop_cycle
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence gap_s;
        !cycle_strobe [*3] ##1 cycle_strobe;
    endsequence
    AST_CYCLE: assert property (cycle_strobe |=> gap_s)
        else $error("strobe spacing wrong");
    AST_CLASS: assert property (cycle_strobe |->
        instr_class == $past(instr_word[13:12])) else $error("class");
    AST_FIELDS: assert property (cycle_strobe |-> opcode ==
        $past(instr_word[13:8]) && file_addr == $past(instr_word[6:0]))
        else $error("byte fields");
    AST_BITS: assert property (cycle_strobe |-> bit_sel ==
        $past(instr_word[9:7]) && literal11 == $past(instr_word[10:0]))
        else $error("bit or jump fields");
    AST_HOLD: assert property (!cycle_strobe |-> $stable(opcode))
        else $error("fields moved mid cycle");
    AST_NOP: assert property (is_nop_cycle |->
        !write_enable && !dest_file && !dest_accum) else $error("nop");
    AST_DEST: assert property (cycle_strobe && write_enable |->
        dest_file == (instr_class == 2'h0 && $past(instr_word[7])))
        else $error("d");
    AST_JUMP: assert property (cycle_strobe && write_enable &&
        instr_class == 2'h2 |-> ##4 is_nop_cycle) else $error("no flush");
    AST_EXEC: assert property (cycle_strobe && !is_nop_cycle |->
        write_enable) else $error("idle write");
    AST_PHASE: assert property (cycle_strobe == (phase_out == 2'h3))
        else $error("phase view out of step with strobe");
endmodule // ifd_props
`default_nettype wire

/* File: testbench/ifd_fetch.sv */
// fetch-path model presenting words and skip results
`timescale 1ns/1ns
`default_nettype none
module ifd_fetch (
    input wire logic ref_clk,
    input wire logic cycle_strobe,
    output logic [13:0] instr_word,
    output logic skip_true
);
    integer seed = 21;
    integer r;
    initial begin
        instr_word = 14'h2F85;
        skip_true = 1'b0;
    end
    // one word in 32 is forced to a return, 0x0008 or 0x0009, so returns get flushed too
    always @(posedge ref_clk) begin
        if (cycle_strobe) begin
            r = $random(seed);
            instr_word <= (r[4:0] == 5'h00) ? {13'h0004, r[5]} :
                r[13:0];
            skip_true <= r[20];
        end
    end
endmodule // ifd_fetch
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the instruction format decoder
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    wire [13:0] instr_word;
    wire skip_true, dest_file, dest_accum, write_enable, is_nop_cycle;
    wire counter_change, cycle_strobe;
    wire [1:0] instr_class, phase_out;
    wire [5:0] opcode;
    wire [2:0] jump_opcode, bit_sel;
    wire [6:0] file_addr;
    wire [7:0] literal8;
    wire [10:0] literal11;
    logic [13:0] w = 14'h2F85;
    logic s = 1'b0;
    logic nop, prev = 1'b0, chg, skp, c0;
    integer n_fail = 0;
    integer num_checks = 0;
    ifd_decoder dut (.*);
    ifd_fetch u_fetch (.*);
    always #5 ref_clk = ~ref_clk;
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // model: w is the word loaded at the last sample edge
    always @(negedge ref_clk) begin
        if (rst_b && cycle_strobe) begin
            nop = prev;
            c0 = w[13:12] == 2'h0;
            chg = w[13:12] == 2'h2 || w[13:10] == 4'hD || w[13:1] == 13'h4 ||
                (c0 && w[7] && w[6:0] == 7'h02);
            skp = s && (w[13:8] == 6'h0B || w[13:8] == 6'h0F ||
                w[13:11] == 3'h3);
            chk("class", instr_class, w[13:12]);
            chk("fields", {opcode, file_addr, bit_sel},
                {w[13:8], w[6:0], w[9:7]});
            chk("jump", {jump_opcode, literal11}, w);
            chk("lit", literal8, w[7:0]);
            chk("dest",
                {dest_file, dest_accum, write_enable, is_nop_cycle},
                {!nop && c0 && w[7], !nop && c0 && !w[7], !nop, nop});
            if (!nop) chk("chg", counter_change, chg);
            prev = !nop && (chg || skp);
        end else begin
            // the word stands from the edge after a strobe until sampled
            w = instr_word;
            s = skip_true;
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2000) @(posedge ref_clk);
        complete_run();
    end
    initial begin
        #40000;
        n_fail++;
        complete_run();
    end
endmodule // tb_top
bind ifd_decoder ifd_props u_props (.*);
`default_nettype wire
